// *** core/dual_adc_mode_sequencer.sv ***
`timescale 1ns/1ps
// Mode sequencer for a primary and an auxiliary sigma-delta converter.
`include "dual_adc_regs.svh"
module dual_adc_mode_sequencer #(
  parameter int RATE_W = 8,
  parameter int UNIT_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic [RATE_W-1:0] filter_rate_word,
  input wire logic no_ext_ref,
  input wire logic primary_clamp,
  input wire logic aux_clamp,
  output logic primary_powered,
  output logic aux_powered,
  output logic primary_mod_reset,
  output logic aux_mod_reset,
  output logic [1:0] primary_source,
  output logic [1:0] aux_source,
  output logic primary_ext_ref,
  output logic aux_ext_ref,
  output logic primary_result_we,
  output logic aux_result_we,
  output logic primary_cal_we,
  output logic aux_cal_we,
  output logic [2:0] cal_kind
);

  if (RATE_W < 1 || RATE_W > 8) begin : g_bad_rate
    $error("dual_adc_mode_sequencer serves filter rate widths of 1 to 8 bits");
  end

  // Register contents.
  dual_adc_pkg::mode_e mode;
  logic en0;
  logic en1;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;

  // Flags.
  logic primary_ready_flag;
  logic auxiliary_ready_flag;
  logic cal_flag;
  logic primary_error_flag;
  logic auxiliary_error_flag;

  // Per-converter work still owed in single or calibration mode.
  logic pending0;
  logic pending1;
  logic aux_realign;

  // Decoded accesses.
  logic wr_mode;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_status;
  dual_adc_pkg::mode_e wr_code;
  logic wr_en0;
  logic wr_en1;
  logic start_write;
  logic cal_write;

  // Sequencing terms.
  logic is_cal;
  logic is_single;
  logic is_cont;
  logic run0;
  logic run1;
  logic restart_both;
  logic restart_aux;
  logic aux_enable_only;
  logic [RATE_W-1:0] rate;
  logic tick0;
  logic tick1;
  logic done0;
  logic done1;
  logic take0;
  logic take1;
  logic aux_temp_sel;
  logic next_pending0;
  logic next_pending1;
  logic finish;

  // Register port decode; each access is a single-cycle strobe.
  assign wr_mode = sfr_wr && sfr_addr == `ADDR_MODE;
  assign wr_ctrl0 = sfr_wr && sfr_addr == `ADDR_CTRL0;
  assign wr_ctrl1 = sfr_wr && sfr_addr == `ADDR_CTRL1;
  assign wr_status = sfr_wr && sfr_addr == `ADDR_STATUS;
  assign wr_code = dual_adc_pkg::mode_e'(sfr_wdata[`MODE_CODE_MSB:`MODE_CODE_LSB]);
  assign wr_en0 = sfr_wdata[`MODE_EN0_BIT];
  assign wr_en1 = sfr_wdata[`MODE_EN1_BIT];
  assign start_write = wr_mode && wr_code >= dual_adc_pkg::MODE_SINGLE;
  assign cal_write = wr_mode && wr_code[2];

  // Mode classes; the top code bit marks every calibration.
  assign is_cal = mode[2];
  assign is_single = mode == dual_adc_pkg::MODE_SINGLE;
  assign is_cont = mode == dual_adc_pkg::MODE_CONTINUOUS;

  // A converter runs only when enabled and the shared mode asks for work.
  assign run0 = en0 && (is_cont || ((is_single || is_cal) && pending0));
  assign run1 = en1 && (is_cont || ((is_single || is_cal) && pending1));

  // A mode write that only raises the auxiliary enable spares a running primary.
  assign aux_enable_only = wr_mode && wr_en1 && !en1 &&
    wr_en0 == en0 && wr_code == mode;
  // Any other mode write, even of the same value, restarts both converters.
  // The primary takes priority: its control write while enabled, or its enable rise, resets both.
  assign restart_both = (wr_mode && !aux_enable_only) || (wr_ctrl0 && en0);
  // Auxiliary control writes and mode writes that only raise the auxiliary enable reset the auxiliary alone.
  assign restart_aux = restart_both || wr_ctrl1 || aux_enable_only;

  // Calibrations ignore the programmed rate; the code being written decides the
  // period loaded at the restart, otherwise the first output would use the old rate.
  assign rate = (wr_mode ? wr_code[2] : is_cal) ? RATE_W'(`FILTER_RATE_MAX) :
    filter_rate_word;

  converter_engine #(
    .RATE_W(RATE_W),
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_primary (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .restart(restart_both),
    .run(run0),
    .rate(rate),
    .use_ext(1'b0),
    .ext_tick(1'b0),
    .settle(`NO_ALIGN_OUTPUTS),
    .tick(tick0),
    .done(done0)
  );

  // The auxiliary steps on primary outputs while the primary runs, so the two
  // never drift in phase; after an auxiliary-only reset it waits three outputs.
  converter_engine #(
    .RATE_W(RATE_W),
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_auxiliary (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .restart(restart_aux),
    .run(run1),
    .rate(rate),
    .use_ext(run0),
    .ext_tick(tick0),
    .settle(aux_realign && run0 ? `AUX_ALIGN_OUTPUTS : `NO_ALIGN_OUTPUTS),
    .tick(tick1),
    .done(done1)
  );

  // A completion is accepted only while the ready flag is clear.
  assign take0 = done0 && run0 && !primary_ready_flag;
  assign take1 = done1 && run1 && !auxiliary_ready_flag;
  assign aux_temp_sel = ctrl1[`CTRL_CH_MSB:`CTRL_CH_LSB] == `AUX_CH_TEMP;

  // Pending work is owed per enabled converter and retired on acceptance.
  always_comb begin
    next_pending0 = pending0;
    next_pending1 = pending1;
    if (take0) begin
      next_pending0 = 1'b0;
    end
    if (take1) begin
      next_pending1 = 1'b0;
    end
  end

  // The operation ends when the last owed converter has delivered.
  assign finish = (is_single || is_cal) && (pending0 || pending1) &&
    !next_pending0 && !next_pending1 && !wr_mode;

  // Pending bits are loaded by a starting mode write, which wins over completion.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending0 <= 1'b0;
      pending1 <= 1'b0;
    end else if (wr_mode) begin
      pending0 <= start_write && wr_en0;
      pending1 <= start_write && wr_en1;
    end else begin
      pending0 <= next_pending0;
      pending1 <= next_pending1;
    end
  end

  // Auxiliary realignment is wanted after a reset that spared the primary.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_realign <= 1'b0;
    end else if (restart_both) begin
      aux_realign <= 1'b0;
    end else if (wr_ctrl1 || aux_enable_only) begin
      aux_realign <= 1'b1;
    end else if (take1) begin
      aux_realign <= 1'b0;
    end
  end

  // Mode register; software writes take priority over the return to power-down.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= dual_adc_pkg::mode_e'(`MODE_RST);
      en0 <= 1'b0;
      en1 <= 1'b0;
    end else if (wr_mode) begin
      mode <= wr_code;
      en0 <= wr_en0;
      en1 <= wr_en1;
    end else if (finish) begin
      mode <= dual_adc_pkg::MODE_POWER_DOWN;
    end
  end

  // Control registers hold reference and channel selection.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0 <= `CTRL0_RST;
      ctrl1 <= `CTRL1_RST;
    end else begin
      if (wr_ctrl0) begin
        ctrl0 <= sfr_wdata;
      end
      if (wr_ctrl1) begin
        ctrl1 <= sfr_wdata;
      end
    end
  end

  // Ready flags: cleared by a starting mode write or by writing zero to the bit.
  status_flag u_primary_ready_flag (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set(take0),
    .clear(start_write || cal_write || (wr_status && !sfr_wdata[`STAT_PRIMARY_READY_FLAG_BIT])),
    .q(primary_ready_flag)
  );

  status_flag u_auxiliary_ready_flag (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set(take1),
    .clear(start_write || cal_write || (wr_status && !sfr_wdata[`STAT_AUXILIARY_READY_FLAG_BIT])),
    .q(auxiliary_ready_flag)
  );

  // Calibration status is set when a calibration returns to power-down.
  status_flag u_cal (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set(finish && is_cal),
    .clear(start_write),
    .q(cal_flag)
  );

  // Errors flag clamped results, or a failed auxiliary calibration.
  status_flag u_primary_error_flag (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set(take0 && !is_cal && primary_clamp),
    .clear(start_write),
    .q(primary_error_flag)
  );

  status_flag u_auxiliary_error_flag (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .set(take1 && (is_cal ? aux_temp_sel : aux_clamp)),
    .clear(start_write),
    .q(auxiliary_error_flag)
  );

  // Write pulses towards the result and coefficient registers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_result_we <= 1'b0;
      aux_result_we <= 1'b0;
      primary_cal_we <= 1'b0;
      aux_cal_we <= 1'b0;
    end else begin
      primary_result_we <= take0 && !is_cal;
      aux_result_we <= take1 && !is_cal;
      primary_cal_we <= take0 && is_cal;
      aux_cal_we <= take1 && is_cal && !aux_temp_sel;
    end
  end

  // Power and hold state of each converter; idle keeps clocks but holds reset.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_powered <= 1'b0;
      aux_powered <= 1'b0;
      primary_mod_reset <= 1'b1;
      aux_mod_reset <= 1'b1;
    end else begin
      primary_powered <= en0 && mode != dual_adc_pkg::MODE_POWER_DOWN;
      aux_powered <= en1 && mode != dual_adc_pkg::MODE_POWER_DOWN;
      primary_mod_reset <= !run0 || restart_both;
      aux_mod_reset <= !run1 || restart_aux;
    end
  end

  // Input routing follows the calibration kind.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_source <= dual_adc_pkg::SRC_CHANNEL;
      aux_source <= dual_adc_pkg::SRC_CHANNEL;
      primary_ext_ref <= 1'b0;
      aux_ext_ref <= 1'b0;
      cal_kind <= 3'h0;
    end else begin
      case (mode)
        dual_adc_pkg::MODE_CAL_INT_ZERO: begin
          primary_source <= dual_adc_pkg::SRC_SHORT;
          aux_source <= dual_adc_pkg::SRC_SHORT;
        end
        dual_adc_pkg::MODE_CAL_INT_FULL: begin
          primary_source <= dual_adc_pkg::SRC_REFERENCE;
          aux_source <= dual_adc_pkg::SRC_REFERENCE;
        end
        default: begin
          // System calibrations sample the selected channel pair.
          primary_source <= dual_adc_pkg::SRC_CHANNEL;
          aux_source <= dual_adc_pkg::SRC_CHANNEL;
        end
      endcase
      primary_ext_ref <= ctrl0[`CTRL_REF_BIT];
      aux_ext_ref <= ctrl1[`CTRL_REF_BIT];
      cal_kind <= mode;
    end
  end

  // Registered read data; unmapped addresses read as zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `ADDR_MODE: sfr_rdata <= {2'h0, en0, en1, 1'b0, mode};
        `ADDR_CTRL0: sfr_rdata <= ctrl0;
        `ADDR_CTRL1: sfr_rdata <= ctrl1;
        `ADDR_STATUS: sfr_rdata <= {primary_ready_flag, auxiliary_ready_flag, cal_flag, no_ext_ref, primary_error_flag, auxiliary_error_flag, 2'h0};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule : dual_adc_mode_sequencer

// *** core/dual_adc_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the mode sequencer.
`ifndef DUAL_ADC_REGS_SVH
`define DUAL_ADC_REGS_SVH

// Register addresses on the special-function register port.
`define ADDR_MODE 8'hD1
`define ADDR_CTRL0 8'hD2
`define ADDR_CTRL1 8'hD3
`define ADDR_STATUS 8'hD8

// Power-on values.
`define MODE_RST 8'h00
`define CTRL0_RST 8'h07
`define CTRL1_RST 8'h00

// Operating mode register fields.
`define MODE_EN0_BIT 5
`define MODE_EN1_BIT 4
`define MODE_CODE_MSB 2
`define MODE_CODE_LSB 0

// Control register fields, same layout for both converters.
`define CTRL_REF_BIT 6
`define CTRL_CH_MSB 5
`define CTRL_CH_LSB 4

// Status register fields.
`define STAT_PRIMARY_READY_FLAG_BIT 7
`define STAT_AUXILIARY_READY_FLAG_BIT 6
`define STAT_CAL_BIT 5
`define STAT_NOREF_BIT 4
`define STAT_PRIMARY_ERROR_FLAG_BIT 3
`define STAT_AUXILIARY_ERROR_FLAG_BIT 2

// Auxiliary channel code that routes the temperature sensor.
`define AUX_CH_TEMP 2'h3

// Filter rate used for every calibration.
`define FILTER_RATE_MAX 8'hFF

// Primary outputs an auxiliary converter may wait to fall into step.
`define AUX_ALIGN_OUTPUTS 2'h3
`define NO_ALIGN_OUTPUTS 2'h1

`endif

// *** core/dual_adc_pkg.sv ***
// Types shared by the converter mode sequencer.
package dual_adc_pkg;

  // Shared three-bit operating mode of both converters.
  typedef enum logic [2:0] {
    MODE_POWER_DOWN = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_SINGLE = 3'b010,
    MODE_CONTINUOUS = 3'b011,
    MODE_CAL_INT_ZERO = 3'b100,
    MODE_CAL_INT_FULL = 3'b101,
    MODE_CAL_SYS_ZERO = 3'b110,
    MODE_CAL_SYS_FULL = 3'b111
  } mode_e;

  // What the converter input is connected to.
  typedef enum logic [1:0] {
    SRC_CHANNEL = 2'b00,
    SRC_SHORT = 2'b01,
    SRC_REFERENCE = 2'b10
  } input_source_e;

endpackage : dual_adc_pkg

// *** core/status_flag.sv ***
`timescale 1ns/1ps
// One sticky status flag: hardware set wins over any clear in the same cycle.
module status_flag (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic set,
  input wire logic clear,
  output logic q
);

  // A set arriving with a clear is kept so no completion is lost.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clear) begin
      q <= 1'b0;
    end
  end

endmodule : status_flag

// *** core/converter_engine.sv ***
`timescale 1ns/1ps
// Output timing of one converter: rate divider, optional external phase and settling count.
module converter_engine #(
  parameter int RATE_W = 8,
  parameter int UNIT_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic run,
  input wire logic [RATE_W-1:0] rate,
  input wire logic use_ext,
  input wire logic ext_tick,
  input wire logic [1:0] settle,
  output logic tick,
  output logic done
);

  localparam int CNT_W = RATE_W + $clog2(UNIT_CYCLES + 1) + 1;

  if (UNIT_CYCLES < 1 || RATE_W < 1) begin : g_bad_param
    $error("converter_engine needs RATE_W and UNIT_CYCLES of at least one");
  end

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] period_m1;
  logic [1:0] seen;

  // One output every (rate + 1) rate units of modulator cycles.
  assign period_m1 = CNT_W'((32'(rate) + 32'd1) * 32'(UNIT_CYCLES) - 32'd1);
  assign tick = run && !restart && (use_ext ? ext_tick : (count == '0));

  // Own divider; it restarts with every converter reset so the phase is known.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (restart || !run || count == '0) begin
      count <= period_m1;
    end else begin
      count <= count - 1'b1;
    end
  end

  // Outputs before the settle count are swallowed while the filter fills.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen <= 2'h0;
      done <= 1'b0;
    end else if (restart || !run) begin
      seen <= 2'h0;
      done <= 1'b0;
    end else begin
      // Widened by one bit so a saturated count of three still compares as four.
      done <= tick && ({1'b0, seen} + 3'h1 >= {1'b0, settle});
      if (tick && seen != 2'h3) begin
        seen <= seen + 2'h1;
      end
    end
  end

endmodule : converter_engine

// *** test/dual_adc_mode_sequencer_monitor.sv ***
// Port-level checker of the converter mode sequencer, bound onto its top module.
`timescale 1ns/1ps
module dual_adc_mode_sequencer_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic primary_powered,
  input wire logic aux_powered,
  input wire logic primary_mod_reset,
  input wire logic aux_mod_reset,
  input wire logic [1:0] primary_source,
  input wire logic primary_result_we,
  input wire logic aux_result_we
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // Decoded writes; a plain net keeps the properties short.
  wire logic mode_wr = sfr_wr && sfr_addr == 8'hD1;
  wire logic ctrl0_wr = sfr_wr && sfr_addr == 8'hD2;
  wire logic ctrl1_wr = sfr_wr && sfr_addr == 8'hD3;

  // Last byte written to the mode register, to spot a write that only raises the
  // auxiliary enable; a stale code only ever weakens the primary check.
  logic [7:0] last_mode;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_mode <= 8'h00;
    end else if (mode_wr) begin
      last_mode <= sfr_wdata;
    end
  end
  wire logic aux_rise_wr = mode_wr && sfr_wdata[4] && !last_mode[4] &&
    sfr_wdata[5] == last_mode[5] && sfr_wdata[2:0] == last_mode[2:0];

  // Steps of a mode change: the write, then bus cycles with no further write.
  sequence s_code_wr(logic [2:0] c);
    mode_wr && sfr_wdata[5] && sfr_wdata[2:0] == c;
  endsequence
  sequence s_idle_quiet;
    s_code_wr(3'h1) ##1 !sfr_wr [*3];
  endsequence

  a_mode_restart:
    assert property (mode_wr && !aux_rise_wr |-> ##[1:2] (primary_mod_reset && aux_mod_reset))
    else $error("mode write left a converter running");
  a_aux_rise:
    assert property (aux_rise_wr && !primary_mod_reset && !primary_result_we |=>
      (!primary_mod_reset && aux_mod_reset))
    else $error("auxiliary enable rise handled wrongly");
  a_ctrl0_restart:
    assert property (ctrl0_wr && primary_powered |-> ##[1:2] (primary_mod_reset && aux_mod_reset))
    else $error("primary control write did not restart both");
  a_aux_only:
    assert property (ctrl1_wr && !primary_mod_reset && !primary_result_we |=> !primary_mod_reset)
    else $error("auxiliary control write disturbed the primary");
  a_one_result:
    assert property (primary_result_we |=> !primary_result_we)
    else $error("result written while ready still set");
  a_idle_held:
    assert property (s_idle_quiet |-> primary_mod_reset && primary_powered)
    else $error("idle did not hold modulator in reset with clocks on");
  a_short_src:
    assert property (s_code_wr(3'h4) |-> ##[1:3] primary_source == 2'h1)
    else $error("zero calibration input not shorted");
  a_ref_src:
    assert property (s_code_wr(3'h5) |-> ##[1:3] primary_source == 2'h2)
    else $error("full calibration input not on reference");
  a_sys_src:
    assert property (s_code_wr(3'h6) |-> ##[1:3] primary_source == 2'h0)
    else $error("system calibration input not on channel");
  a_en0_off:
    assert property (mode_wr && !sfr_wdata[5] |-> ##[1:2] !primary_powered)
    else $error("disabled primary still powered");
  a_aux_off:
    assert property (mode_wr && !sfr_wdata[4] |-> ##[1:2] (!aux_powered && !aux_result_we))
    else $error("disabled auxiliary still active");
endmodule : dual_adc_mode_sequencer_monitor

bind dual_adc_mode_sequencer dual_adc_mode_sequencer_monitor mon_u (
  .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .primary_powered(primary_powered), .aux_powered(aux_powered),
  .primary_mod_reset(primary_mod_reset), .aux_mod_reset(aux_mod_reset),
  .primary_source(primary_source), .primary_result_we(primary_result_we),
  .aux_result_we(aux_result_we)
);

// *** test/tb_dual_adc_mode_sequencer.sv ***
// Self-checking testbench of the converter mode sequencer.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("[FAIL] %0t got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module tb_dual_adc_mode_sequencer;
  localparam int UNIT = 1;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] filter_rate_word = 8'h00;
  logic no_ext_ref = 1'b0;
  logic primary_clamp = 1'b0;
  logic aux_clamp = 1'b0;
  logic [7:0] sfr_rdata;
  logic primary_powered, aux_powered, primary_mod_reset, aux_mod_reset;
  logic [1:0] primary_source, aux_source;
  logic primary_ext_ref, aux_ext_ref, primary_result_we, aux_result_we;
  logic primary_cal_we, aux_cal_we;
  logic [2:0] cal_kind;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int cnt [4] = '{0, 0, 0, 0};
  int misaligned = 0;
  logic [31:0] seed = 32'h39B6B4F8;
  logic [7:0] ra [4] = '{8'hD1, 8'hD2, 8'hD3, 8'hD8};
  logic [7:0] rv [4] = '{8'h00, 8'h07, 8'h00, 8'h00};
  logic [7:0] rd_val;
  logic [7:0] rate;
  int dt, t0, n0, n1, m0;

  dual_adc_mode_sequencer #(.RATE_W(8), .UNIT_CYCLES(UNIT)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .filter_rate_word(filter_rate_word), .no_ext_ref(no_ext_ref),
    .primary_clamp(primary_clamp), .aux_clamp(aux_clamp),
    .primary_powered(primary_powered), .aux_powered(aux_powered),
    .primary_mod_reset(primary_mod_reset), .aux_mod_reset(aux_mod_reset),
    .primary_source(primary_source), .aux_source(aux_source),
    .primary_ext_ref(primary_ext_ref), .aux_ext_ref(aux_ext_ref),
    .primary_result_we(primary_result_we), .aux_result_we(aux_result_we),
    .primary_cal_we(primary_cal_we), .aux_cal_we(aux_cal_we), .cal_kind(cal_kind)
  );

  // Clock at 100 MHz.
  always #5 core_clk = ~core_clk;

  // Pulse counters and watchdog; non-blocking updates keep the tasks free of races.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (primary_result_we) cnt[0] <= cnt[0] + 1;
    if (aux_result_we) cnt[1] <= cnt[1] + 1;
    if (primary_cal_we) cnt[2] <= cnt[2] + 1;
    if (aux_cal_we) cnt[3] <= cnt[3] + 1;
    if (aux_result_we && !primary_result_we) misaligned <= misaligned + 1;
    if (cyc == 5000) begin
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
    end
  end

  // Repeatable xorshift source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Output period in cycles for a rate setting.
  function automatic int per(input logic [7:0] r);
    return (int'(r) + 1) * UNIT;
  endfunction : per

  // Input source expected for each calibration code.
  function automatic logic [1:0] exp_src(input logic [2:0] c);
    if (c == 3'h4) return dual_adc_pkg::SRC_SHORT;
    if (c == 3'h5) return dual_adc_pkg::SRC_REFERENCE;
    return dual_adc_pkg::SRC_CHANNEL;
  endfunction : exp_src

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask : rd

  // Bounded wait for the next pulse of one counter; d counts from the start cycle t.
  task automatic wait_ev(input int sel, input int t, input int lim, output int d);
    int snap;
    snap = cnt[sel];
    while (cnt[sel] == snap && cyc - t < lim) begin
      @(posedge core_clk);
      #1;
    end
    d = cyc - t;
  endtask : wait_ev

  task automatic new_rate();
    // At least three cycles per output, so flag clears every two cycles never block one.
    rate = 8'(rnd() & 32'h7) + 8'h02;
    @(posedge core_clk);
    filter_rate_word <= rate;
  endtask : new_rate

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Main sequence: reset, then one block per behaviour.
  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], rd_val);
      `CHK(rd_val, rv[i])
    end
    wr({4'h4, 4'(rnd())}, 8'(rnd()));
    rd({4'h4, 4'(rnd())}, rd_val);
    `CHK(rd_val, 8'h00)
    $display("reset values done");
    new_rate();
    wr(8'hD1, 8'h22);
    t0 = cyc;
    wait_ev(0, t0, per(rate) + 8, dt);
    `CHK(dt >= per(rate) && dt <= per(rate) + 6, 1'b1)
    rd(8'hD1, rd_val);
    `CHK(rd_val, 8'h20)
    rd(8'hD8, rd_val);
    `CHK(rd_val, 8'h80)
    `CHK(cnt[1], 0)
    $display("single conversion done");
    new_rate();
    primary_clamp <= 1'b1;
    wr(8'hD1, 8'h23);
    n0 = cnt[0];
    wait_ev(0, cyc, per(rate) + 8, dt);
    repeat (per(rate) * 4) @(posedge core_clk);
    #1;
    `CHK(cnt[0], n0 + 1)
    rd(8'hD8, rd_val);
    `CHK(rd_val, 8'h88)
    wr(8'hD8, 8'h00);
    wait_ev(0, cyc, per(rate) + 8, dt);
    `CHK(dt <= per(rate) + 4, 1'b1)
    wr(8'hD2, 8'h07);
    wr(8'hD1, 8'h23);
    primary_clamp <= 1'b0;
    wr(8'hD1, 8'h22);
    rd(8'hD8, rd_val);
    `CHK(rd_val & 8'hEC, 8'h00)
    wait_ev(0, cyc, per(rate) + 8, dt);
    $display("continuous and ready done");
    new_rate();
    aux_clamp <= 1'(rnd());
    wr(8'hD1, 8'h33);
    repeat (8) wr(8'hD8, 8'h00);
    wr(8'hD1, 8'h23);
    wr(8'hD1, 8'h33);
    #1;
    `CHK(primary_mod_reset, 1'b0)
    n0 = cnt[0];
    n1 = cnt[1];
    m0 = misaligned;
    wr(8'hD3, 8'h00);
    repeat (24) wr(8'hD8, 8'h00);
    `CHK(cnt[1] > n1, 1'b1)
    `CHK(misaligned, m0)
    `CHK(cnt[0] >= n0 + 3, 1'b1)
    $display("auxiliary alignment done");
    for (int c = 4; c < 8; c++) begin
      new_rate();
      wr(8'hD1, 8'h20 | 8'(c));
      t0 = cyc;
      rd(8'hD8, rd_val);
      `CHK(rd_val[7:6], 2'h0)
      `CHK(primary_source, exp_src(3'(c)))
      `CHK(cal_kind, 3'(c))
      wait_ev(2, t0, 300, dt);
      `CHK(dt >= 256 * UNIT && dt <= 256 * UNIT + 6, 1'b1)
      rd(8'hD1, rd_val);
      `CHK(rd_val, 8'h20)
      rd(8'hD8, rd_val);
      `CHK(rd_val & 8'hE0, 8'hA0)
    end
    $display("calibrations done");
    wr(8'hD3, 8'h70);
    wr(8'hD1, 8'h14);
    n1 = cnt[3];
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(aux_source, dual_adc_pkg::SRC_SHORT)
    `CHK(aux_ext_ref, 1'b1)
    wait_ev(3, cyc, 300, dt);
    `CHK(cnt[3], n1)
    rd(8'hD8, rd_val);
    `CHK(rd_val & 8'h44, 8'h44)
    $display("temperature calibration done");
    wr(8'hD1, 8'h21);
    repeat (5) @(posedge core_clk);
    #1;
    `CHK(primary_mod_reset, 1'b1)
    `CHK(primary_powered, 1'b1)
    wr(8'hD1, 8'h03);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(primary_powered, 1'b0)
    `CHK(aux_powered, 1'b0)
    $display("idle and disable done");
    wrap_up();
  end
endmodule : tb_dual_adc_mode_sequencer
